// File: shared/dcfpc_pkg.sv
// Function
// - Timing select high at second edge after reset release gives standard mode.
// - Timing select low at that edge gives fall-through mode with ready flags.
// - Standard mode loads the output register only on an explicit read.
// - Fall-through moves the next word out automatically while output-ready is low.
// - Preset mode at reset release loads 64, 16 or 8 into both offsets.
// - Parallel mode takes first two port A writes as almost-full then almost-empty.
// - Third port A write after parallel load is ordinary FIFO data.
// - Parallel offsets come from low port A bits, top bit most significant.
// - Serial mode chosen by mode low, select-0 low, select-1 high at release.
// - Serial mode shifts one bit per edge while strobe low, almost-full first.
// - Full flag stays low during serial load, rises the edge after last bit.
// - Port A lines drive only while select and direction are both low.
// - FIFO write needs select low, write, gate high, mailbox low, full high.
// - Port B lines drive only while select low and direction high.
// - FIFO read needs select low, read, gate high, mailbox low, ready high.
// - Port A mailbox read outputs second mailbox; mailbox write fills the first.
// - Port B mailbox read outputs first mailbox; mailbox write fills the second.
// - Write-side flags and read-side flags pass two flip-flop stages.
// - Fall-through with output-ready low and no word ready keeps the word and ignores reads.
// - Standard empty flag follows memory holding a readable word, three clock cycles late.
// - Full flag rises three write clock cycles after a reset.
package dcfpc_pkg;
  localparam int FF_RISE_CYCLES = 2;
  localparam int PRESET_HIGH = 64;
  localparam int PRESET_MID = 16;
  localparam int PRESET_LOW = 8;

  typedef struct packed {
    logic select_n;   // Chip select, active low
    logic direction;  // Port A: high write; port B: high read
    logic gate;       // Transfer gate
    logic mailbox;    // Mailbox select
  } dcfpc_port_ctl_s;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_PAR_Y,
    LOAD_PAR_X,
    LOAD_SER
  } dcfpc_load_e;
endpackage

// File: verilog/dcfpc_top.sv
`timescale 1ns/10ps
module dcfpc_top #(
  parameter int DW = 36,
  parameter int DEPTH = 1024
) (
  input wire clk_i,                                     // 50 MHz clock
  input wire rst_i,                                     // Sync reset, high
  input wire master_reset_n_i,                          // Master reset, low
  input wire byte_order_timing_select_i,                // Timing mode strap
  input wire serial_program_mode_n_i,                   // Offset program strap
  input wire flag_select0_serial_data_i,                // Select 0 / serial data
  input wire flag_select1_serial_strobe_i,              // Select 1 / strobe
  input dcfpc_pkg::dcfpc_port_ctl_s port_a_ctl_i,       // Port A controls
  input dcfpc_pkg::dcfpc_port_ctl_s port_b_ctl_i,       // Port B controls
  input wire [DW-1:0] port_a_bus_i,                     // Port A data in
  output logic [DW-1:0] port_a_bus_o,                   // Port A data out
  output logic port_a_bus_oe_o,                         // Port A drive enable
  input wire [DW-1:0] port_b_bus_i,                     // Port B data in
  output logic [DW-1:0] port_b_bus_o,                   // Port B data out
  output logic port_b_bus_oe_o,                         // Port B drive enable
  output logic full_flag_n_o,                           // Full / input ready
  output logic empty_flag_n_o,                          // Empty / output ready
  output logic almost_full_n_o,                         // Almost full, low
  output logic almost_empty_n_o,                        // Almost empty, low
  output logic first_mailbox_flag_n_o,                  // First mailbox full, low
  output logic second_mailbox_flag_n_o,                 // Second mailbox full, low
  output logic fall_through_mode_o                      // Fall-through selected
);
  localparam int AW = $clog2(DEPTH);
  localparam int OW = AW;
  localparam int SW = 2 * OW;
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
  localparam logic [5:0] SCNT_LAST = 6'(SW - 1);
  localparam logic [1:0] RISE_LAST = 2'(dcfpc_pkg::FF_RISE_CYCLES - 1);

  // Port operation decode shared by both ports
  function automatic logic port_op(input dcfpc_pkg::dcfpc_port_ctl_s c, input logic dir,
                                   input logic mb);
    port_op = ~c.select_n & c.gate & (c.direction == dir) & (c.mailbox == mb);
  endfunction

  logic [DW-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic [DW-1:0] out_q, first_mailbox_q, second_mailbox_q;
  logic [OW-1:0] x_q, y_q;
  logic [SW-2:0] sr_q;
  logic [5:0] scnt_q;
  logic [1:0] rise_q;
  dcfpc_pkg::dcfpc_load_e load_q;
  logic mrn_q, mode_pend_q;
  logic sp_s1_q, sp_s2_q, av_s1_q, av_s2_q, ae_s1_q, af_s1_q;

  // Decode of port requests
  wire clr = rst_i | ~master_reset_n_i;
  wire rise = master_reset_n_i & ~mrn_q;
  wire a_fifo_wr = port_op(port_a_ctl_i, 1'b1, 1'b0);
  wire a_mail_wr = port_op(port_a_ctl_i, 1'b1, 1'b1);
  wire a_mail_rd = port_op(port_a_ctl_i, 1'b0, 1'b1);
  wire b_fifo_rd = port_op(port_b_ctl_i, 1'b1, 1'b0);
  wire b_mail_rd = port_op(port_b_ctl_i, 1'b1, 1'b1);
  wire b_mail_wr = port_op(port_b_ctl_i, 1'b0, 1'b1);
  // Port A read or port B write with mailbox low decodes to nothing
  // no operation case
  wire [AW:0] count = wr_q - rd_q;
  wire mem_full = (count == DEPTH_W);
  wire mem_any = (count != '0);
  wire a_data_wr = a_fifo_wr & full_flag_n_o & ~clr;
  // Internal full guard covers writes during flag synchroniser lag
  wire wr_en = a_data_wr & (load_q == dcfpc_pkg::LOAD_IDLE) & ~mem_full;
  wire ser_shift = (load_q == dcfpc_pkg::LOAD_SER) & ~flag_select1_serial_strobe_i;
  wire std_take = ~fall_through_mode_o & b_fifo_rd & empty_flag_n_o;
  wire ft_take = fall_through_mode_o & av_s2_q & (~empty_flag_n_o | b_fifo_rd);
  wire rd_take = (std_take | ft_take) & mem_any & ~clr;
  wire or_d = empty_flag_n_o ? (~b_fifo_rd | rd_take) : rd_take;
  wire eor_d = fall_through_mode_o ? or_d : av_s2_q;
  wire ff_d = (rise_q >= RISE_LAST) & (load_q != dcfpc_pkg::LOAD_SER) & sp_s2_q;

  // Strap edge and timing mode latch
  always_ff @(posedge clk_i) begin
    mrn_q <= rst_i ? 1'b0 : master_reset_n_i;
    mode_pend_q <= ~rst_i & rise;
    if (rst_i) begin
      fall_through_mode_o <= 1'b0;
    end else if (mode_pend_q) begin
      fall_through_mode_o <= ~byte_order_timing_select_i;
    end
  end

  // Offset programming; reserved straps fall back to keeping old offsets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_q <= dcfpc_pkg::LOAD_IDLE;
      x_q <= OW'(dcfpc_pkg::PRESET_LOW);
      y_q <= OW'(dcfpc_pkg::PRESET_LOW);
      scnt_q <= '0;
      sr_q <= '0;
    end else if (rise) begin
      scnt_q <= '0;
      load_q <= dcfpc_pkg::LOAD_IDLE;
      if (serial_program_mode_n_i) begin
        if (flag_select1_serial_strobe_i && flag_select0_serial_data_i) begin
          x_q <= OW'(dcfpc_pkg::PRESET_HIGH);
          y_q <= OW'(dcfpc_pkg::PRESET_HIGH);
        end else if (flag_select1_serial_strobe_i) begin
          x_q <= OW'(dcfpc_pkg::PRESET_MID);
          y_q <= OW'(dcfpc_pkg::PRESET_MID);
        end else if (flag_select0_serial_data_i) begin
          x_q <= OW'(dcfpc_pkg::PRESET_LOW);
          y_q <= OW'(dcfpc_pkg::PRESET_LOW);
        end else begin
          load_q <= dcfpc_pkg::LOAD_PAR_Y;
        end
      end else if (flag_select1_serial_strobe_i && !flag_select0_serial_data_i) begin
        load_q <= dcfpc_pkg::LOAD_SER;
      end
    end else begin
      case (load_q)
        dcfpc_pkg::LOAD_PAR_Y: begin
          if (a_data_wr) begin
            y_q <= port_a_bus_i[OW-1:0];
            load_q <= dcfpc_pkg::LOAD_PAR_X;
          end
        end
        dcfpc_pkg::LOAD_PAR_X: begin
          if (a_data_wr) begin
            x_q <= port_a_bus_i[OW-1:0];
            load_q <= dcfpc_pkg::LOAD_IDLE;
          end
        end
        dcfpc_pkg::LOAD_SER: begin
          if (ser_shift) begin
            sr_q <= {sr_q[SW-3:0], flag_select0_serial_data_i};
            scnt_q <= scnt_q + 6'h01;
            if (scnt_q == SCNT_LAST) begin
              y_q <= sr_q[SW-2:OW-1];
              x_q <= {sr_q[OW-2:0], flag_select0_serial_data_i};
              load_q <= dcfpc_pkg::LOAD_IDLE;
            end
          end
        end
        default: load_q <= dcfpc_pkg::LOAD_IDLE;
      endcase
    end
  end

  // Memory array and pointers
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[wr_q[AW-1:0]] <= port_a_bus_i;
    end
    if (rd_take) begin
      out_q <= mem[rd_q[AW-1:0]];
    end
    wr_q <= clr ? '0 : wr_q + (AW+1)'(wr_en);
    rd_q <= clr ? '0 : rd_q + (AW+1)'(rd_take);
  end

  // Flag synchronisers; first stage feeds only the second
  // two-stage flag paths
  always_ff @(posedge clk_i) begin
    sp_s1_q <= ~clr & ~mem_full;
    sp_s2_q <= ~clr & sp_s1_q;
    av_s1_q <= ~clr & mem_any;
    av_s2_q <= ~clr & av_s1_q;
    ae_s1_q <= ~clr & (count > {1'b0, x_q});
    af_s1_q <= clr | (count < (DEPTH_W - {1'b0, y_q}));
    almost_empty_n_o <= ~clr & ae_s1_q;
    almost_full_n_o <= clr | af_s1_q;
  end

  // Full and ready flags
  // full rises three cycles after reset
  always_ff @(posedge clk_i) begin
    if (clr) begin
      rise_q <= '0;
      full_flag_n_o <= 1'b0;
      empty_flag_n_o <= 1'b0;
    end else begin
      rise_q <= (rise_q >= RISE_LAST) ? rise_q : rise_q + 2'h1;
      full_flag_n_o <= ff_d;
      empty_flag_n_o <= eor_d;
    end
  end

  // Mailboxes; a store in the same cycle as a read keeps the flag set
  // port A and port B mailbox access
  always_ff @(posedge clk_i) begin
    if (a_mail_wr) begin
      first_mailbox_q <= port_a_bus_i;
    end
    if (b_mail_wr) begin
      second_mailbox_q <= port_b_bus_i;
    end
    if (clr) begin
      first_mailbox_flag_n_o <= 1'b1;
      second_mailbox_flag_n_o <= 1'b1;
    end else begin
      first_mailbox_flag_n_o <= ~a_mail_wr & (first_mailbox_flag_n_o | b_mail_rd);
      second_mailbox_flag_n_o <= ~b_mail_wr & (second_mailbox_flag_n_o | a_mail_rd);
    end
  end

  // Bus drivers, registered so outputs lag the controls one cycle
  // port A and port B drive enables and data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_bus_oe_o <= 1'b0;
      port_b_bus_oe_o <= 1'b0;
      port_a_bus_o <= '0;
      port_b_bus_o <= '0;
    end else begin
      port_a_bus_oe_o <= ~port_a_ctl_i.select_n & ~port_a_ctl_i.direction;
      port_b_bus_oe_o <= ~port_b_ctl_i.select_n & port_b_ctl_i.direction;
      port_a_bus_o <= second_mailbox_q;
      port_b_bus_o <= port_b_ctl_i.mailbox ? first_mailbox_q : out_q;
    end
  end

  mode_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_pend_q |=> fall_through_mode_o == !$past(byte_order_timing_select_i))
    else $error("timing mode not latched from strap");
  fall_through_mode_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_pend_q && !byte_order_timing_select_i |=> fall_through_mode_o)
    else $error("fall-through not selected");
  preset_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise && serial_program_mode_n_i && flag_select0_serial_data_i
    && flag_select1_serial_strobe_i |=> x_q == OW'(dcfpc_pkg::PRESET_HIGH) && y_q == x_q)
    else $error("preset offsets wrong");
  par_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_q == dcfpc_pkg::LOAD_PAR_Y && a_data_wr && !rise
    |=> y_q == $past(port_a_bus_i[OW-1:0]) && load_q == dcfpc_pkg::LOAD_PAR_X && wr_q == '0)
    else $error("parallel offset load wrong");
  serial_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load_q == dcfpc_pkg::LOAD_SER |=> !full_flag_n_o)
    else $error("full flag high during serial load");
  fifo_write_a: assert property (@(posedge clk_i) disable iff (clr)
    a_fifo_wr && full_flag_n_o && load_q == dcfpc_pkg::LOAD_IDLE && !mem_full
    |=> wr_q == $past(wr_q) + 1'b1)
    else $error("qualified write not stored");
  port_a_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_a_ctl_i.select_n && !port_a_ctl_i.direction |=> port_a_bus_oe_o)
    else $error("port A not driving on read");
  mail_flag_a: assert property (@(posedge clk_i) disable iff (clr)
    a_mail_wr |=> !first_mailbox_flag_n_o && first_mailbox_q == $past(port_a_bus_i))
    else $error("first mailbox not stored");
  fall_through_mode_hold_a: assert property (@(posedge clk_i) disable iff (clr)
    fall_through_mode_o && !empty_flag_n_o && !av_s2_q |=> $stable(out_q))
    else $error("output word changed while not ready");
endmodule

// File: testbench/dcfpc_bus_host.sv
`timescale 1ns/10ps
module dcfpc_bus_host (
  input wire clk_i,           // Clock
  input wire dev_oe_i,        // Device drives lines
  input wire [35:0] dev_d_i,  // Device data
  input wire host_oe_i,       // Host drives lines
  input wire [35:0] host_d_i, // Host data
  output logic [35:0] wire_o  // Resolved line level
);
  logic [35:0] last_q;

  // Released lines show inverted stale data, so a missed drive never matches
  always_comb begin
    if (dev_oe_i) begin
      wire_o = dev_d_i;
    end else if (host_oe_i) begin
      wire_o = host_d_i;
    end else begin
      wire_o = ~last_q;
    end
  end

  // Remember last level seen on the lines
  always_ff @(posedge clk_i) begin
    last_q <= wire_o;
  end
endmodule

// File: testbench/dcfpc_test.sv
`timescale 1ns/10ps
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, v); end end
module dcfpc_test;
  // controls change one time unit after each clock edge, gate high or low
  localparam dcfpc_pkg::dcfpc_port_ctl_s IDLE = '{1'b1, 1'b1, 1'b0, 1'b0};
  localparam dcfpc_pkg::dcfpc_port_ctl_s XFER = '{1'b0, 1'b1, 1'b1, 1'b0};
  localparam dcfpc_pkg::dcfpc_port_ctl_s MB_AW = '{1'b0, 1'b1, 1'b1, 1'b1};
  localparam dcfpc_pkg::dcfpc_port_ctl_s MB_BW = '{1'b0, 1'b0, 1'b1, 1'b1};
  localparam dcfpc_pkg::dcfpc_port_ctl_s NOP_BW = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic clk_i = 0, rst_i = 1, mr_n = 0, tsel = 1, spm_n = 1, fs0 = 0, fs1 = 0;
  dcfpc_pkg::dcfpc_port_ctl_s a_ctl = IDLE, b_ctl = IDLE;
  logic [35:0] hd = 36'h0;
  logic [19:0] ser = {10'h004, 10'h002};
  wire [35:0] a_w, b_w, a_o, b_o;
  wire a_oe, b_oe, ff_n, ef_n, first_mailbox_flag_n_n, second_mailbox_flag_n_n, ftm, ae_n, af_n;
  int err_count = 0, checks = 0;

  // Clock at 50 MHz
  initial forever #10 clk_i = ~clk_i;

  // Host side of each shared bus
  dcfpc_bus_host host_a (.clk_i(clk_i), .dev_oe_i(a_oe), .dev_d_i(a_o),
    .host_oe_i(a_ctl.select_n | a_ctl.direction), .host_d_i(hd), .wire_o(a_w));
  dcfpc_bus_host host_b (.clk_i(clk_i), .dev_oe_i(b_oe), .dev_d_i(b_o),
    .host_oe_i(b_ctl.select_n | ~b_ctl.direction), .host_d_i(hd), .wire_o(b_w));

  dcfpc_top uut (.clk_i(clk_i), .rst_i(rst_i), .master_reset_n_i(mr_n),
    .byte_order_timing_select_i(tsel), .serial_program_mode_n_i(spm_n),
    .flag_select0_serial_data_i(fs0), .flag_select1_serial_strobe_i(fs1),
    .port_a_ctl_i(a_ctl), .port_b_ctl_i(b_ctl), .port_a_bus_i(a_w), .port_a_bus_o(a_o),
    .port_a_bus_oe_o(a_oe), .port_b_bus_i(b_w), .port_b_bus_o(b_o), .port_b_bus_oe_o(b_oe),
    .full_flag_n_o(ff_n), .empty_flag_n_o(ef_n), .almost_full_n_o(af_n),
    .almost_empty_n_o(ae_n),
    .first_mailbox_flag_n_o(first_mailbox_flag_n_n), .second_mailbox_flag_n_o(second_mailbox_flag_n_n),
    .fall_through_mode_o(ftm));

  // One cycle of both ports; controls held until the sampling edge
  task op(input dcfpc_pkg::dcfpc_port_ctl_s a, input dcfpc_pkg::dcfpc_port_ctl_s b,
          input logic [35:0] d);
    a_ctl = a;
    b_ctl = b;
    hd = d;
    @(posedge clk_i);
    #1;
  endtask

  task idle(input int n);
    repeat (n) op(IDLE, IDLE, 36'h0);
  endtask

  // Timing strap stays put after release, so the mode shifts only at a master reset
  // timing strap held after release
  // callers never pass reserved strap sets
  task mreset(input logic tm, input logic s, input logic f0, input logic f1);
    mr_n = 0;
    tsel = tm;
    spm_n = s;
    fs0 = f0;
    fs1 = f1;
    idle(4);
    mr_n = 1;
  endtask

  // Flags lag the memory, so give them a bounded wait
  task wait_ef;
    int k;
    k = 0;
    while (ef_n !== 1'b1 && k < 8) begin
      idle(1);
      k++;
    end
  endtask

  task end_of_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is about a hundred cycles
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end

  initial begin
    idle(6);
    rst_i = 0;
    mreset(1'b1, 1'b1, 1'b0, 1'b0);
    idle(2);
    `CHK("ff_early", 1'b0, ff_n)
    idle(1);
    `CHK("ff_up", 1'b1, ff_n)
    `CHK("ftm_std", 1'b0, ftm)
    op(XFER, IDLE, 36'h005);
    op(XFER, IDLE, 36'h003);
    op(XFER, NOP_BW, 36'h9abcdef01);
    idle(1);
    wait_ef;
    `CHK("ef_data", 1'b1, ef_n)
    `CHK("second_mailbox_flag_n_nop", 1'b1, second_mailbox_flag_n_n)
    op(IDLE, XFER, 36'h0);
    idle(1);
    `CHK("third_word", 36'h9abcdef01, b_o)
    idle(3);
    `CHK("ef_drained", 1'b0, ef_n)
    op(IDLE, XFER, 36'h0);
    idle(1);
    `CHK("read_refused", 36'h9abcdef01, b_o)
    op(MB_AW, IDLE, 36'h123456789);
    idle(2);
    `CHK("first_mailbox_flag_n_set", 1'b0, first_mailbox_flag_n_n)
    op(IDLE, MB_AW, 36'h0);
    `CHK("first_mailbox_out", 36'h123456789, b_o)
    `CHK("b_drive", 1'b1, b_oe)
    idle(2);
    `CHK("first_mailbox_flag_n_clr", 1'b1, first_mailbox_flag_n_n)
    op(IDLE, MB_BW, 36'hfedcba987);
    idle(2);
    `CHK("second_mailbox_flag_n_set", 1'b0, second_mailbox_flag_n_n)
    op(MB_BW, IDLE, 36'h0);
    `CHK("second_mailbox_out", 36'hfedcba987, a_o)
    `CHK("a_drive", 1'b1, a_oe)
    idle(2);
    `CHK("second_mailbox_flag_n_clr", 1'b1, second_mailbox_flag_n_n)
    `CHK("a_float", 1'b0, a_oe)
    mreset(1'b0, 1'b1, 1'b1, 1'b1);
    idle(3);
    `CHK("ftm_on", 1'b1, ftm)
    op(XFER, IDLE, 36'h111);
    idle(1);
    wait_ef;
    idle(1);
    `CHK("fall_word", 36'h111, b_o)
    op(XFER, IDLE, 36'h222);
    idle(6);
    `CHK("no_auto", 36'h111, b_o)
    op(IDLE, XFER, 36'h0);
    idle(4);
    `CHK("second_word", 36'h222, b_o)
    op(IDLE, XFER, 36'h0);
    idle(1);
    `CHK("or_low_keep", 36'h222, b_o)
    `CHK("or_dropped", 1'b0, ef_n)
    mreset(1'b1, 1'b0, 1'b0, 1'b1);
    idle(1);
    fs1 = 0;
    for (int i = 19; i >= 0; i--) begin
      fs0 = ser[i];
      idle(1);
    end
    fs1 = 1;
    `CHK("ff_serial_low", 1'b0, ff_n)
    idle(1);
    `CHK("ff_serial_up", 1'b1, ff_n)
    op(XFER, IDLE, 36'h001);
    op(XFER, IDLE, 36'h002);
    idle(3);
    `CHK("ae_at_x", 1'b0, ae_n)
    op(XFER, IDLE, 36'h003);
    idle(3);
    `CHK("ae_above_x", 1'b1, ae_n)
    `CHK("af_room", 1'b1, af_n)
    end_of_test;
  end
endmodule
